// file: core/scsc_pkg.sv
// package: constants and types of the sense configuration switch control
package scsc_pkg;

	// ------------------------------------------------------------
	// clock and bus
	// ------------------------------------------------------------
	localparam int unsigned CLK_HZ  = 50_000_000;
	localparam int unsigned ADDR_W  = 12;
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STATUS = 12'h004;
	localparam logic [11:0] OFS_PERIOD = 12'h008;
	localparam logic [11:0] OFS_WIDTH  = 12'h00C;

	// ------------------------------------------------------------
	// control register fields and reset values
	// ------------------------------------------------------------
	localparam int unsigned CB_BEMF = 0;
	localparam int unsigned CB_METH = 1;
	localparam int unsigned CB_CSSH = 2;
	localparam int unsigned CB_EMSH = 3;
	localparam int unsigned CB_CMP  = 4;
	localparam int unsigned CB_EXTN = 5;
	localparam int unsigned CTRL_W  = 6;
	localparam logic [5:0]  CTRL_RST = 6'h00;

	// status layout: config, interface mode, fixed switch set
	localparam int unsigned SB_CFG    = 0;
	localparam int unsigned SB_SERIAL = 4;
	localparam int unsigned SB_FIX    = 8;

	// ------------------------------------------------------------
	// sample/hold timing
	// ------------------------------------------------------------
	localparam int unsigned SH_PERIOD_NS = 1000;
	localparam int unsigned SH_WIDTH_NS  = 200;
	localparam int unsigned SH_PERIOD_CY = SH_PERIOD_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int unsigned SH_WIDTH_CY  = (SH_WIDTH_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam logic [15:0] PERIOD_RST   = 16'(SH_PERIOD_CY);
	localparam logic [15:0] WIDTH_RST    = 16'(SH_WIDTH_CY);

	// ------------------------------------------------------------
	// configurations, select codes, straps
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		CFG_NONE = 4'h0, CFG_1 = 4'h1, CFG_2 = 4'h2, CFG_3 = 4'h3, CFG_4 = 4'h4,
		CFG_5 = 4'h5, CFG_6 = 4'h6, CFG_7 = 4'h7, CFG_8 = 4'h8, CFG_9 = 4'h9
	} scsc_cfg_t;

	// two-pin select: 00 first, 01 second, 1x third
	localparam logic [1:0] SEL_FIRST  = 2'h0;
	localparam logic [1:0] SEL_SECOND = 2'h1;
	localparam logic [1:0] STRAP_CFG6 = 2'h0;
	localparam logic [1:0] STRAP_CFG7 = 2'h1;
	localparam logic [1:0] STRAP_CFG4 = 2'h2;

	// fixed switch set: 0 aux amps on emf, 1 phase c amp on emf, 2 phase b
	// negative on phase a sense, 3 phase c amp on shunt, 4 on-resistance
	// path, 5 comparator out, 6 current hold path, 7 emf hold path
	localparam logic [7:0] FIX_T [0:9] = '{
		8'h00, 8'hC7, 8'h47, 8'h87, 8'h07, 8'h48, 8'h08, 8'h10, 8'h13, 8'hE3
	};

endpackage : scsc_pkg

// file: core/scsc_cfg_decode.sv
// module: picks the sensing configuration from control bits or straps
`timescale 1ns/1ps
module scsc_cfg_decode (
	input  wire logic              serial_mode,
	input  wire logic [5:0]        ctrl_bits,
	input  wire logic [1:0]        strap_code,
	output scsc_pkg::scsc_cfg_t    cfg
);
	import scsc_pkg::*;

	// ------------------------------------------------------------
	// field split
	// ------------------------------------------------------------
	wire logic bemf = ctrl_bits[CB_BEMF];
	wire logic meth = ctrl_bits[CB_METH];
	wire logic cssh = ctrl_bits[CB_CSSH];
	wire logic emsh = ctrl_bits[CB_EMSH];
	wire logic cmp  = ctrl_bits[CB_CMP];

	// ------------------------------------------------------------
	// serial decode; the comparator mode wins over every other bit
	// ------------------------------------------------------------
	wire scsc_cfg_t emf_shunt = cssh ? (emsh ? CFG_1 : CFG_2)
	                                 : (emsh ? CFG_3 : CFG_4);
	wire scsc_cfg_t cur_shunt = cssh ? CFG_5 : CFG_6;
	// on-resistance with current hold is not a supported pair
	wire scsc_cfg_t cur_rds   = cssh ? CFG_NONE : CFG_7;
	wire scsc_cfg_t ser_cfg   = cmp ? CFG_9 :
	                            bemf ? (meth ? CFG_8 : emf_shunt) :
	                            (meth ? cur_rds : cur_shunt);

	// straps reach only the continuous configurations
	wire scsc_cfg_t hw_cfg = (strap_code == STRAP_CFG6) ? CFG_6 :
	                         (strap_code == STRAP_CFG7) ? CFG_7 :
	                         (strap_code == STRAP_CFG4) ? CFG_4 : CFG_8;

	assign cfg = serial_mode ? ser_cfg : hw_cfg;

endmodule : scsc_cfg_decode

// file: core/scsc_sh_timer.sv
// module: periodic sample window for the sample/hold switches
`timescale 1ns/1ps
module scsc_sh_timer #(
	parameter int unsigned CNT_W = 16
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic             ce,
	input  wire logic             run,
	input  wire logic [CNT_W-1:0] period,
	input  wire logic [CNT_W-1:0] width,
	output logic                  sample
);
	import scsc_pkg::*;

	// ------------------------------------------------------------
	// counter
	// ------------------------------------------------------------
	if (CNT_W < 2) begin : g_chk
		$error("scsc_sh_timer: CNT_W below 2");
	end

	logic [CNT_W-1:0] cnt_reg;
	logic             sample_reg;
	// a period of zero or one still wraps, the count then stays at zero and the window stays open for any nonzero width
	wire logic              wrap     = (cnt_reg + 1'b1 >= period);
	wire logic [CNT_W-1:0]  cnt_next = (!run || wrap) ? '0 : cnt_reg + 1'b1;
	wire logic              win      = run && (cnt_reg < width);

	// counter clears to zero and window closes while no hold path is enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_reg    <= '0;
			sample_reg <= 1'b0;
		end else if (ce) begin
			cnt_reg    <= cnt_next;
			sample_reg <= win;
		end
	end

	assign sample = sample_reg;

endmodule : scsc_sh_timer

// file: core/scsc_switch_ctrl.sv
// module: top of the current and back-emf sense switch control
//
// Overview of operation
// - config 1: emf, shunt, both holds
// - config 2: emf, shunt, current hold
// - config 3: emf, shunt, emf hold
// - config 4: emf, shunt, continuous, strap or serial
// - config 5: three shunts, all held, muxed
// - config 6: three shunts, continuous
// - config 7: low-side sensing while transistor on
// - config 8: emf plus two-phase on-resistance
// - config 9: comparator mode, emf and phase a
// - phase pins enable exactly one phase switch in emf configs
// - external or virtual neutral, never both
// - config 1 output pins pick one held signal
// - config 2 picks continuous emf or held currents
// - held emf feeds the emf output switch, except in config 9
// - hold switches follow enabled hold paths
// - emf configs limit shunt sensing to a,b
// - phase b negative joins phase a sense in configs 1 to 4
// - fixed switches steady through a configuration
`timescale 1ns/1ps
module scsc_switch_ctrl #(
	parameter int unsigned TIMER_W = 16
) (
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       ce,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [scsc_pkg::ADDR_W-1:0] paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic      [31:0]                prdata,
	output logic                            pready,
	output logic                            pslverr,
	input  wire logic                       deadtime_interface_strap_pin,
	input  wire logic [1:0]                 mode_strap_serial_out_pin,
	input  wire logic                       phase_select_pin_1,
	input  wire logic                       phase_select_pin_2,
	input  wire logic                       output_select_pin_1,
	input  wire logic                       output_select_pin_0,
	input  wire logic [2:0]                 low_side_on,
	output logic                            sw_select_phase_a,
	output logic                            sw_select_phase_b,
	output logic                            sw_select_phase_c,
	output logic                            sw_external_neutral,
	output logic                            sw_virtual_neutral,
	output logic                            sw_out_emf,
	output logic                            sw_out_current_b,
	output logic                            sw_out_current_a,
	output logic                            sample_hold_switch_x,
	output logic                            sample_hold_switch_y,
	output logic                            sample_hold_switch_z,
	output logic      [2:0]                 sw_low_side,
	output logic      [7:0]                 fixed_switch_set,
	output logic      [3:0]                 active_config
);
	import scsc_pkg::*;

	// ------------------------------------------------------------
	// parameter check
	// ------------------------------------------------------------
	if (TIMER_W < 8 || TIMER_W > 16) begin : g_chk
		$error("scsc_switch_ctrl: TIMER_W must be 8 to 16");
	end

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic [CTRL_W-1:0]  ctrl_reg;
	logic [TIMER_W-1:0] period_reg;
	logic [TIMER_W-1:0] width_reg;
	logic               serial_reg;
	logic [1:0]         strap_reg;
	logic               strap_done_reg;
	logic               pready_reg;
	logic               pslverr_reg;
	logic [31:0]        prdata_reg;
	logic [15:0]        sw_reg;
	logic [7:0]         fix_reg;
	scsc_cfg_t          cfg_reg;

	// ------------------------------------------------------------
	// apb decode
	// ------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	wire logic acc     = psel && penable && !pready_reg;
	wire logic fire    = psel && penable && pready_reg;
	wire logic hit_c   = (paddr == OFS_CTRL);
	wire logic hit_s   = (paddr == OFS_STATUS);
	wire logic hit_p   = (paddr == OFS_PERIOD);
	wire logic hit_w   = (paddr == OFS_WIDTH);
	wire logic mapped  = hit_c || hit_s || hit_p || hit_w;
	wire logic wr      = fire && pwrite && ce;
	wire logic [31:0] bmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
	wire logic [31:0] ctrl_wide = {{(32 - CTRL_W){1'b0}}, ctrl_reg};
	wire logic [31:0] per_wide  = {{(32 - TIMER_W){1'b0}}, period_reg};
	wire logic [31:0] wid_wide  = {{(32 - TIMER_W){1'b0}}, width_reg};
	wire logic [31:0] ctrl_m    = (ctrl_wide & ~bmask) | (pwdata & bmask);
	wire logic [31:0] per_m     = (per_wide & ~bmask) | (pwdata & bmask);
	wire logic [31:0] wid_m     = (wid_wide & ~bmask) | (pwdata & bmask);
	wire logic [CTRL_W-1:0]  ctrl_next   = (wr && hit_c) ? ctrl_m[CTRL_W-1:0] : ctrl_reg;
	wire logic [TIMER_W-1:0] period_next = (wr && hit_p) ? per_m[TIMER_W-1:0] : period_reg;
	wire logic [TIMER_W-1:0] width_next  = (wr && hit_w) ? wid_m[TIMER_W-1:0] : width_reg;

	// status shows the block's own state, reserved bits read zero
	wire logic [31:0] status_word = {16'h0000, fix_reg, 3'h0, serial_reg, cfg_reg};
	wire logic [31:0] rd_mux = hit_c ? ctrl_wide : hit_s ? status_word :
	                           hit_p ? per_wide : hit_w ? wid_wide : 32'h0000_0000;

	// bus registers; the clock enable also stalls the bus
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			pslverr_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else if (ce) begin
			pready_reg  <= acc;
			pslverr_reg <= acc && !mapped;
			prdata_reg  <= (acc && !pwrite) ? rd_mux : 32'h0000_0000;
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg   <= CTRL_RST;
			period_reg <= PERIOD_RST[TIMER_W-1:0];
			width_reg  <= WIDTH_RST[TIMER_W-1:0];
		end else if (ce) begin
			ctrl_reg   <= ctrl_next;
			period_reg <= period_next;
			width_reg  <= width_next;
		end
	end

	// ------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------
	// straps are caught on the first enabled edge after reset, never
	// under the reset itself; serial mode is the default until then
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_reg     <= 1'b1;
			strap_reg      <= STRAP_CFG6;
			strap_done_reg <= 1'b0;
		end else if (ce && !strap_done_reg) begin
			serial_reg     <= deadtime_interface_strap_pin;
			strap_reg      <= mode_strap_serial_out_pin;
			strap_done_reg <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// configuration and hold timing
	// ------------------------------------------------------------
	scsc_cfg_t cfg;
	logic      sample;

	scsc_cfg_decode u_decode (
		.serial_mode (serial_reg),
		.ctrl_bits   (ctrl_reg),
		.strap_code  (strap_reg),
		.cfg         (cfg)
	);

	// configuration class wires
	wire logic emf_cfg  = (cfg == CFG_1) || (cfg == CFG_2) || (cfg == CFG_3) ||
	                      (cfg == CFG_4) || (cfg == CFG_8) || (cfg == CFG_9);
	wire logic mux_cfg  = (cfg == CFG_1) || (cfg == CFG_2) || (cfg == CFG_3) ||
	                      (cfg == CFG_5);
	wire logic hold_x   = (cfg == CFG_1) || (cfg == CFG_3) || (cfg == CFG_5) ||
	                      (cfg == CFG_9);
	wire logic hold_yz  = (cfg == CFG_1) || (cfg == CFG_2) || (cfg == CFG_5);
	wire logic hold_z   = hold_yz || (cfg == CFG_9);

	scsc_sh_timer #(
		.CNT_W (TIMER_W)
	) u_timer (
		.pclk    (pclk),
		.presetn (presetn),
		.ce      (ce),
		.run     (hold_x || hold_z),
		.period  (period_reg),
		.width   (width_reg),
		.sample  (sample)
	);

	// ------------------------------------------------------------
	// dynamic switch selection
	// ------------------------------------------------------------
	wire logic [1:0] ph_code  = {phase_select_pin_2, phase_select_pin_1};
	wire logic [1:0] out_code = {output_select_pin_1, output_select_pin_0};
	// third code covers both upper values so one switch is always picked
	wire logic ph_a  = emf_cfg && (ph_code == SEL_FIRST);
	wire logic ph_b  = emf_cfg && (ph_code == SEL_SECOND);
	wire logic ph_c  = emf_cfg && ph_code[1];
	wire logic n_ext = emf_cfg && ctrl_reg[CB_EXTN];
	wire logic n_vir = emf_cfg && !ctrl_reg[CB_EXTN];
	wire logic o_a   = mux_cfg && (out_code == SEL_FIRST);
	wire logic o_b   = mux_cfg && (out_code == SEL_SECOND);
	wire logic o_emf = mux_cfg && out_code[1];
	wire logic sh_x  = hold_x && sample;
	wire logic sh_y  = hold_yz && sample;
	wire logic sh_z  = hold_z && sample;
	// each low side senses only while its transistor conducts; the
	// phase c path is given to the emf chain in config 8
	wire logic [2:0] ls_next = (cfg == CFG_7) ? low_side_on :
	                           (cfg == CFG_8) ? {1'b0, low_side_on[1:0]} : 3'b000;
	// unsupported bits land on CFG_NONE and every term above goes low
	wire logic [15:0] sw_next = {2'b00, ls_next, sh_z, sh_y, sh_x, o_a, o_b, o_emf,
	                             n_vir, n_ext, ph_c, ph_b, ph_a};

	// switch outputs and fixed set register together with the config
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_reg  <= 16'h0000;
			fix_reg <= 8'h00;
			cfg_reg <= CFG_NONE;
		end else if (ce) begin
			sw_reg  <= sw_next;
			fix_reg <= FIX_T[cfg];
			cfg_reg <= cfg;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign prdata               = prdata_reg;
	assign pready               = pready_reg;
	assign pslverr              = pslverr_reg;
	assign sw_select_phase_a    = sw_reg[0];
	assign sw_select_phase_b    = sw_reg[1];
	assign sw_select_phase_c    = sw_reg[2];
	assign sw_external_neutral  = sw_reg[3];
	assign sw_virtual_neutral   = sw_reg[4];
	assign sw_out_emf           = sw_reg[5];
	assign sw_out_current_b     = sw_reg[6];
	assign sw_out_current_a     = sw_reg[7];
	assign sample_hold_switch_x = sw_reg[8];
	assign sample_hold_switch_y = sw_reg[9];
	assign sample_hold_switch_z = sw_reg[10];
	assign sw_low_side          = sw_reg[13:11];
	assign fixed_switch_set     = fix_reg;
	assign active_config        = cfg_reg;

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	wire logic q_emf = (cfg_reg == CFG_1) || (cfg_reg == CFG_2) || (cfg_reg == CFG_3) ||
	                   (cfg_reg == CFG_4) || (cfg_reg == CFG_8) || (cfg_reg == CFG_9);
	wire logic [2:0] q_out = sw_reg[7:5];
	wire logic q_mux = (cfg_reg == CFG_1) || (cfg_reg == CFG_2) || (cfg_reg == CFG_3) ||
	                   (cfg_reg == CFG_5);

	AST_CFG1_SERIAL: assert property (
		(wr && hit_c && pstrb[0] && serial_reg && pwdata[4:0] == 5'b01101) ##1 ce
		|=> cfg_reg == CFG_1)
		else $error("serial write for config 1 did not select it");
	AST_CFG3_HOLD: assert property (
		cfg_reg == CFG_3 |-> !sample_hold_switch_y && !sample_hold_switch_z)
		else $error("config 3 closed a current hold switch");
	AST_CFG5_HOLD: assert property (
		cfg_reg == CFG_5 |-> (sw_reg[8] == sw_reg[9]) && (sw_reg[9] == sw_reg[10]))
		else $error("config 5 hold switches not in step");
	AST_LOWSIDE: assert property (
		(ce && cfg == CFG_7 && cfg_reg == CFG_7) |=> sw_low_side == $past(low_side_on))
		else $error("low side switches do not follow conducting phases");
	AST_PHASE_ONEHOT: assert property (
		q_emf |-> $onehot(sw_reg[2:0]))
		else $error("emf config without exactly one phase switch");
	AST_NEUTRAL: assert property (
		q_emf |-> (sw_external_neutral ^ sw_virtual_neutral))
		else $error("neutral switches not exclusive");
	AST_CFG1_OUT: assert property (
		cfg_reg == CFG_1 |-> $onehot(q_out))
		else $error("config 1 without exactly one output switch");
	AST_CFG2_HOLD: assert property (
		cfg_reg == CFG_2 |-> !sample_hold_switch_x)
		else $error("config 2 closed the emf hold switch");
	AST_FIXED_STEADY: assert property (
		(ce && $stable(cfg_reg)) |=> $stable(fixed_switch_set) || $changed(cfg_reg))
		else $error("fixed switch set moved inside a configuration");
	AST_INVALID: assert property (
		cfg_reg == CFG_NONE |-> (sw_reg[13:0] == 14'h0000) && $onehot0(q_out))
		else $error("unsupported setting drives a dynamic switch");

	// dynamic switches track the pins one enabled edge late
	AST_PHASE_FOLLOW: assert property (
		(q_emf && $past(ce)) |-> sw_select_phase_c == $past(phase_select_pin_2) &&
		sw_select_phase_b == ($past(phase_select_pin_1) && !$past(phase_select_pin_2)))
		else $error("phase switch does not follow the select pins");
	AST_OUT_FOLLOW: assert property (
		(q_mux && $past(ce)) |-> sw_out_emf == $past(output_select_pin_1))
		else $error("output switch does not follow the select pins");
	AST_CFG2_OUT: assert property (
		cfg_reg == CFG_2 |-> $onehot(q_out))
		else $error("config 2 without exactly one output switch");
	AST_STATIC_OFF: assert property (
		!q_emf |-> sw_reg[4:0] == 5'h00)
		else $error("phase or neutral switch closed outside an emf config");
	AST_CFG8_LS: assert property (
		cfg_reg == CFG_8 |-> !sw_low_side[2])
		else $error("config 8 closed the phase c low side switch");
	AST_CFG9_NOMUX: assert property (
		cfg_reg == CFG_9 |-> q_out == 3'b000)
		else $error("config 9 closed an output switch");
	AST_STRAP_CONT: assert property (
		(!serial_reg && !$past(serial_reg)) |-> cfg_reg inside {CFG_4, CFG_6, CFG_7, CFG_8})
		else $error("straps selected a configuration that needs the serial port");

	// a low enable must freeze every register, the bus included, so a
	// stalled core never sees half a transfer
	AST_CE_FREEZE: assert property (
		!$past(ce) |-> $stable({sw_reg, fix_reg, cfg_reg, ctrl_reg, pready_reg, prdata_reg}))
		else $error("state moved while the clock enable was low");

	// bus answers: one wait state, error and data only beside ready
	AST_PREADY: assert property (
		(psel && penable && !pready && ce) |=> pready ##1 (!pready || !$past(ce)))
		else $error("pready not a single cycle after one wait");
	AST_SLVERR: assert property (
		pslverr |-> pready)
		else $error("bus error shown without ready");
	AST_RDATA_IDLE: assert property (
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data not zero outside a ready cycle");

	// main scenarios reached by the bench
	COV_CFG1_EMF:  cover property (cfg_reg == CFG_1 && sw_out_emf);
	COV_CFG9_HOLD: cover property (cfg_reg == CFG_9 && sample_hold_switch_x);
	COV_CFG7_LS:   cover property (cfg_reg == CFG_7 && sw_low_side[2]);
	COV_BAD_ADDR:  cover property (pready && pslverr);
	COV_CFG2_EMF:  cover property (cfg_reg == CFG_2 && sw_out_emf);

endmodule : scsc_switch_ctrl

// file: dv/scsc_mcu_model.sv
// partner: controller driving phase, output-select and low-side levels
`timescale 1ns/1ps
module scsc_mcu_model (
	input  wire logic  pclk,
	input  wire logic  step,
	input  wire logic [6:0] lvl,
	output logic       p1,
	output logic       p2,
	output logic       o1,
	output logic       o0,
	output logic [2:0] lso
);
	// new levels only on request, so the bench knows when they are steady;
	// levels come from the bench so one seeded generator feeds every pin
	initial {p2, p1, o1, o0, lso} = 7'h00;
	always @(posedge pclk) begin
		if (step) {p2, p1, o1, o0, lso} <= lvl;
	end
endmodule : scsc_mcu_model

// file: dv/tb.sv
// testbench: switch control against a behavioural reference
`timescale 1ns/1ps
module tb;
	import scsc_pkg::*;
	logic        pclk = 0, presetn = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
	logic        step = 0, strap = 1, pready, pslverr, p1, p2, o1, o0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [1:0]  mcode = 2'h0;
	logic [2:0]  lso, sls, hold;
	logic [6:0]  lvl = 7'h00;
	logic [7:0]  sw, fix;
	logic [3:0]  acfg;
	logic        sa, sb, sc, sen, svn, soe, sob, soa, hx, hy, hz;
	int          miscompares = 0, n_tests = 0, cyc = 0, f;
	int          strap_cfg [4] = '{6, 7, 4, 8};

	scsc_mcu_model mcu (.pclk(pclk), .step(step), .lvl(lvl), .p1(p1), .p2(p2), .o1(o1),
		.o0(o0), .lso(lso));
	scsc_switch_ctrl DUT (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.deadtime_interface_strap_pin(strap), .mode_strap_serial_out_pin(mcode),
		.phase_select_pin_1(p1), .phase_select_pin_2(p2), .output_select_pin_1(o1),
		.output_select_pin_0(o0), .low_side_on(lso), .sw_select_phase_a(sa),
		.sw_select_phase_b(sb), .sw_select_phase_c(sc), .sw_external_neutral(sen),
		.sw_virtual_neutral(svn), .sw_out_emf(soe), .sw_out_current_b(sob),
		.sw_out_current_a(soa), .sample_hold_switch_x(hx), .sample_hold_switch_y(hy),
		.sample_hold_switch_z(hz), .sw_low_side(sls), .fixed_switch_set(fix),
		.active_config(acfg));

	// ----------------------------------------
	// clock, timeout, reporting
	// ----------------------------------------
	always #10 pclk = ~pclk;

	// ceiling well above the ~4200 cycles the sequence needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end

	task print_verdict();
		$display("checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		// only the global cycle ceiling ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask : apb

	// reference decode of the control bits into a configuration number
	function automatic int ecfg(input int c);
		if (c[4]) return 9;
		if (c[0]) return c[1] ? 8 : (c[2] ? (c[3] ? 1 : 2) : (c[3] ? 3 : 4));
		return c[1] ? (c[2] ? 0 : 7) : (c[2] ? 5 : 6);
	endfunction : ecfg

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(30));
		repeat (10) @(posedge pclk);
		presetn <= 1;
		repeat (3) @(posedge pclk);
		chk("cfg_after_reset", 6, acfg);
		apb(0, OFS_CTRL, 0);
		chk("ctrl_reset", 32'(CTRL_RST), rd);
		apb(0, OFS_PERIOD, 0);
		chk("period_reset", 32'(PERIOD_RST), rd);
		apb(0, OFS_WIDTH, 0);
		chk("width_reset", 32'(WIDTH_RST), rd);
		apb(0, OFS_STATUS, 0);
		chk("status", {16'h0000, FIX_T[6], 8'h16}, rd);
		apb(1, 12'h010, 32'hFFFF_FFFF);
		chk("unmapped_err", 1, er);
		// every control combination, pins re-randomised six times each
		for (int c = 0; c < 64; c++) begin
			apb(1, OFS_CTRL, c);
			f = ecfg(c);
			hold = 3'h0;
			for (int k = 0; k < 6; k++) begin
				step <= 1;
				lvl <= 7'($urandom);
				@(posedge pclk);
				step <= 0;
				repeat (9) begin
					@(posedge pclk);
					hold = hold | {hx, hy, hz};
				end
				sw[7] = f inside {1, 2, 3, 4, 8, 9} && !p2 && !p1;
				sw[6] = f inside {1, 2, 3, 4, 8, 9} && !p2 && p1;
				sw[5] = f inside {1, 2, 3, 4, 8, 9} && p2;
				sw[4] = f inside {1, 2, 3, 4, 8, 9} && c[5];
				sw[3] = f inside {1, 2, 3, 4, 8, 9} && !c[5];
				sw[2] = f inside {1, 2, 3, 5} && o1;
				sw[1] = f inside {1, 2, 3, 5} && !o1 && o0;
				sw[0] = f inside {1, 2, 3, 5} && !o1 && !o0;
				chk("active_config", f, acfg);
				chk("switches", sw, {sa, sb, sc, sen, svn, soe, sob, soa});
				chk("low_side", lso & (f == 7 ? 3'h7 : f == 8 ? 3'h3 : 3'h0), sls);
				chk("fixed_set", FIX_T[f], fix);
			end
			chk("hold_paths", {f inside {1, 3, 5, 9}, f inside {1, 2, 5},
				f inside {1, 2, 5, 9}}, hold);
		end
		// clock enable low: new pin levels and the hold timer move nothing
		ce <= 0;
		step <= 1;
		lvl <= 7'($urandom);
		@(posedge pclk);
		step <= 0;
		rd = {14'h0000, hx, hy, hz, sa, sb, sc, acfg, fix};
		repeat (8) @(posedge pclk);
		chk("ce_freeze", rd, {14'h0000, hx, hy, hz, sa, sb, sc, acfg, fix});
		ce <= 1;
		// strap-selected configurations, one reset each
		for (int m = 0; m < 4; m++) begin
			presetn <= 0;
			strap <= 0;
			mcode <= 2'(m);
			repeat (10) @(posedge pclk);
			presetn <= 1;
			repeat (4) @(posedge pclk);
			chk("strap_config", strap_cfg[m], acfg);
		end
		print_verdict();
	end
endmodule : tb
